// ===== include/two_wire_seq_regs.svh
`ifndef TWO_WIRE_SEQ_REGS_SVH
`define TWO_WIRE_SEQ_REGS_SVH
// Contract
// - software alone decides which modes are legal; hardware imposes no limit.
// - direction bit after seven-bit target address is high for a read.
// - direction bit after target address is low for a write.
// - receiver acknowledges a byte by holding data line low.
// - negative acknowledge leaves data line high during acknowledge bit.
// - each data field is one eight-bit byte plus an acknowledge bit.
// - at every flag set software must act or bus stays stalled.
// - next action is chosen from the masked status code.
// - after loading data, write flag and enable together to send byte.
// - compare masked status with data-sent-acked code; else handle error.
// - flag, enable and stop written together send stop; hardware clears stop.

// device register indices on the device port
`define DEV_CONTROL_IDX 2'h0
`define DEV_STATUS_IDX 2'h1
`define DEV_DATA_IDX 2'h2

// control_reg bit positions
`define CTL_FLAG_BIT 7
`define CTL_ACKEN_BIT 6
`define CTL_START_BIT 5
`define CTL_STOP_BIT 4
`define CTL_WCOL_BIT 3
`define CTL_EN_BIT 2

// status codes and mask
`define STATUS_MASK 8'hF8
`define CODE_START 8'h08
`define CODE_ADDR_ACK 8'h18
`define CODE_ADDR_NACK 8'h20
`define CODE_DATA_ACK 8'h28
`define CODE_ARB_LOST 8'h38

// host register byte offsets
`define HOST_CMD_OFS 5'h00
`define HOST_TARGET_OFS 5'h04
`define HOST_TXDATA_OFS 5'h08
`define HOST_STATUS_OFS 5'h0C
`define HOST_PRESC_OFS 5'h10

// host field positions
`define CMD_GO_BIT 0
`define CMD_READ_BIT 1
`define CMD_STOP_BIT 2
`define ST_BUSY_BIT 0
`define ST_DONE_BIT 1
`define ST_ERR_BIT 2
`define ST_ARB_BIT 3
`define ST_WCOL_BIT 4
`define ST_CODE_LSB 8
`endif

// ===== include/two_wire_seq_pkg.sv
package two_wire_seq_pkg;
    typedef enum logic [3:0] {
        S_IDLE,
        S_PRESC,
        S_START,
        S_POLL,
        S_POLL_CHK,
        S_STAT,
        S_STAT_CHK,
        S_LOAD,
        S_KICK,
        S_STOP,
        S_STOP_POLL,
        S_STOP_CHK,
        S_DONE
    } state_t;

    typedef enum logic [1:0] {
        PH_START,
        PH_ADDR,
        PH_DATA
    } phase_t;
endpackage

// ===== core/two_wire_mode_sequencer.sv
// Register access over Avalon-MM and the register addresses were left to the implementer.
`include "two_wire_seq_regs.svh"

module two_wire_mode_sequencer #(
    parameter int PRESC_W = 2
) (
    input wire logic CLK_SYS, // 40 MHz system clock
    input wire logic NRST, // async reset, active low
    input wire logic [4:0] AVS_ADDRESS, // byte address
    input wire logic AVS_READ, // read request
    input wire logic AVS_WRITE, // write request
    input wire logic [31:0] AVS_WRITEDATA, // write data
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // stall
    output logic [1:0] DEV_ADDR, // device register index
    output logic DEV_WR, // device write strobe
    output logic DEV_RD, // device read strobe
    output logic [7:0] DEV_WDATA, // device write data
    input wire logic [7:0] DEV_RDATA // device read data, valid cycle after DEV_RD
);

    two_wire_seq_pkg::state_t state_reg, state_next;
    two_wire_seq_pkg::phase_t phase_reg, phase_next;
    logic read_dir_reg;
    logic stop_end_reg;
    logic [6:0] target_reg;
    logic [7:0] txdata_reg;
    logic [PRESC_W-1:0] presc_reg;
    logic done_reg, err_reg, arb_reg, wcol_reg;
    logic [7:0] code_reg;
    logic ack_reg;
    logic [1:0] dev_addr_next;
    logic [7:0] dev_wdata_next;
    logic [7:0] masked;
    logic go, bus_wr, bus_rd, set_done, set_err, set_arb, set_wcol;

    function automatic logic [7:0] ctl_word(input logic start, input logic stop);
        logic [7:0] w;
        w = 8'h00;
        w[`CTL_FLAG_BIT] = 1'b1;
        w[`CTL_EN_BIT] = 1'b1;
        w[`CTL_START_BIT] = start;
        w[`CTL_STOP_BIT] = stop;
        return w;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle per access

    // write lands only at the edge where waitrequest is low
    assign bus_wr = AVS_WRITE & ack_reg;
    assign bus_rd = AVS_READ & ~ack_reg;
    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign go = bus_wr && AVS_ADDRESS == `HOST_CMD_OFS && AVS_WRITEDATA[`CMD_GO_BIT]
        && state_reg == two_wire_seq_pkg::S_IDLE;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (AVS_READ | AVS_WRITE) & ~ack_reg;
        end
    end

    // settings are frozen while a transfer runs
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            read_dir_reg <= 1'b0;
            stop_end_reg <= 1'b0;
            target_reg <= 7'h00;
            txdata_reg <= 8'h00;
            presc_reg <= '0;
        end else if (bus_wr && state_reg == two_wire_seq_pkg::S_IDLE) begin
            case (AVS_ADDRESS)
                `HOST_CMD_OFS: begin
                    read_dir_reg <= AVS_WRITEDATA[`CMD_READ_BIT];
                    stop_end_reg <= AVS_WRITEDATA[`CMD_STOP_BIT];
                end
                `HOST_TARGET_OFS: target_reg <= AVS_WRITEDATA[6:0];
                `HOST_TXDATA_OFS: txdata_reg <= AVS_WRITEDATA[7:0];
                `HOST_PRESC_OFS: presc_reg <= AVS_WRITEDATA[PRESC_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (bus_rd) begin
            AVS_READDATA <= 32'h0000_0000;
            case (AVS_ADDRESS)
                `HOST_CMD_OFS: begin
                    AVS_READDATA[`CMD_READ_BIT] <= read_dir_reg;
                    AVS_READDATA[`CMD_STOP_BIT] <= stop_end_reg;
                end
                `HOST_TARGET_OFS: AVS_READDATA[6:0] <= target_reg;
                `HOST_TXDATA_OFS: AVS_READDATA[7:0] <= txdata_reg;
                `HOST_STATUS_OFS: begin
                    AVS_READDATA[`ST_BUSY_BIT] <= state_reg != two_wire_seq_pkg::S_IDLE;
                    AVS_READDATA[`ST_DONE_BIT] <= done_reg;
                    AVS_READDATA[`ST_ERR_BIT] <= err_reg;
                    AVS_READDATA[`ST_ARB_BIT] <= arb_reg;
                    AVS_READDATA[`ST_WCOL_BIT] <= wcol_reg;
                    AVS_READDATA[`ST_CODE_LSB +: 8] <= code_reg;
                end
                `HOST_PRESC_OFS: AVS_READDATA[PRESC_W-1:0] <= presc_reg;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sticky result flags: a new event beats a clear in the same cycle

    logic clr_flags;
    assign clr_flags = bus_wr && AVS_ADDRESS == `HOST_STATUS_OFS;

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            arb_reg <= 1'b0;
            wcol_reg <= 1'b0;
        end else begin
            done_reg <= set_done | (done_reg & ~go & ~(clr_flags & AVS_WRITEDATA[`ST_DONE_BIT]));
            err_reg <= set_err | (err_reg & ~go & ~(clr_flags & AVS_WRITEDATA[`ST_ERR_BIT]));
            arb_reg <= set_arb | (arb_reg & ~go & ~(clr_flags & AVS_WRITEDATA[`ST_ARB_BIT]));
            wcol_reg <= set_wcol | (wcol_reg & ~go & ~(clr_flags & AVS_WRITEDATA[`ST_WCOL_BIT]));
        end
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            code_reg <= 8'h00;
        end else if (state_reg == two_wire_seq_pkg::S_STAT_CHK) begin
            code_reg <= masked;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer

    assign masked = DEV_RDATA & `STATUS_MASK;

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        set_done = 1'b0;
        set_err = 1'b0;
        set_arb = 1'b0;
        set_wcol = 1'b0;
        case (state_reg)
            two_wire_seq_pkg::S_IDLE: begin
                if (go) begin
                    state_next = two_wire_seq_pkg::S_PRESC;
                end
            end
            two_wire_seq_pkg::S_PRESC: begin
                state_next = two_wire_seq_pkg::S_START;
            end
            two_wire_seq_pkg::S_START: begin
                phase_next = two_wire_seq_pkg::PH_START;
                state_next = two_wire_seq_pkg::S_POLL;
            end
            two_wire_seq_pkg::S_POLL: begin
                state_next = two_wire_seq_pkg::S_POLL_CHK;
            end
            two_wire_seq_pkg::S_POLL_CHK: begin
                // wait while device holds the bus
                if (DEV_RDATA[`CTL_FLAG_BIT]) begin
                    state_next = two_wire_seq_pkg::S_STAT;
                end else begin
                    state_next = two_wire_seq_pkg::S_POLL;
                end
            end
            two_wire_seq_pkg::S_STAT: begin
                state_next = two_wire_seq_pkg::S_STAT_CHK;
            end
            two_wire_seq_pkg::S_STAT_CHK: begin
                case (phase_reg)
                    two_wire_seq_pkg::PH_START: begin
                        if (masked == `CODE_START) begin
                            phase_next = two_wire_seq_pkg::PH_ADDR;
                            state_next = two_wire_seq_pkg::S_LOAD;
                        end else begin
                            set_err = 1'b1;
                            state_next = two_wire_seq_pkg::S_DONE;
                        end
                    end
                    two_wire_seq_pkg::PH_ADDR: begin
                        // three address outcomes; ack on write, arbitration lost, or stop (nack, or ack on read)
                        if (masked == `CODE_ADDR_ACK && !read_dir_reg) begin
                            phase_next = two_wire_seq_pkg::PH_DATA;
                            state_next = two_wire_seq_pkg::S_LOAD;
                        end else if (masked == `CODE_ARB_LOST) begin
                            set_arb = 1'b1;
                            set_err = 1'b1;
                            state_next = two_wire_seq_pkg::S_DONE;
                        end else begin
                            set_err = masked != `CODE_ADDR_ACK;
                            state_next = two_wire_seq_pkg::S_STOP;
                        end
                    end
                    default: begin
                        set_err = masked != `CODE_DATA_ACK;
                        if (stop_end_reg || masked != `CODE_DATA_ACK) begin
                            state_next = two_wire_seq_pkg::S_STOP;
                        end else begin
                            state_next = two_wire_seq_pkg::S_DONE;
                        end
                    end
                endcase
            end
            two_wire_seq_pkg::S_LOAD: begin
                state_next = two_wire_seq_pkg::S_KICK;
            end
            two_wire_seq_pkg::S_KICK: begin
                state_next = two_wire_seq_pkg::S_POLL;
            end
            two_wire_seq_pkg::S_STOP: begin
                state_next = two_wire_seq_pkg::S_STOP_POLL;
            end
            two_wire_seq_pkg::S_STOP_POLL: begin
                state_next = two_wire_seq_pkg::S_STOP_CHK;
            end
            two_wire_seq_pkg::S_STOP_CHK: begin
                set_wcol = DEV_RDATA[`CTL_WCOL_BIT];
                if (DEV_RDATA[`CTL_STOP_BIT]) begin
                    state_next = two_wire_seq_pkg::S_STOP_POLL;
                end else begin
                    state_next = two_wire_seq_pkg::S_DONE;
                end
            end
            two_wire_seq_pkg::S_DONE: begin
                set_done = 1'b1;
                state_next = two_wire_seq_pkg::S_IDLE;
            end
            default: begin
                state_next = two_wire_seq_pkg::S_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state_reg <= two_wire_seq_pkg::S_IDLE;
            phase_reg <= two_wire_seq_pkg::PH_START;
        end else begin
            state_reg <= state_next;
            phase_reg <= phase_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // device port: address and data registered for the state being entered

    assign DEV_WR = state_reg == two_wire_seq_pkg::S_PRESC || state_reg == two_wire_seq_pkg::S_START
        || state_reg == two_wire_seq_pkg::S_LOAD || state_reg == two_wire_seq_pkg::S_KICK
        || state_reg == two_wire_seq_pkg::S_STOP;
    assign DEV_RD = state_reg == two_wire_seq_pkg::S_POLL || state_reg == two_wire_seq_pkg::S_STAT
        || state_reg == two_wire_seq_pkg::S_STOP_POLL;

    always_comb begin
        dev_addr_next = `DEV_CONTROL_IDX;
        dev_wdata_next = 8'h00;
        case (state_next)
            two_wire_seq_pkg::S_PRESC: begin
                // prescaler kept in the low status bits
                dev_addr_next = `DEV_STATUS_IDX;
                dev_wdata_next = {{(8 - PRESC_W){1'b0}}, presc_reg};
            end
            two_wire_seq_pkg::S_START: begin
                dev_wdata_next = ctl_word(1'b1, 1'b0);
            end
            two_wire_seq_pkg::S_STAT: begin
                dev_addr_next = `DEV_STATUS_IDX;
            end
            two_wire_seq_pkg::S_LOAD: begin
                // data written only after the flag was seen high
                dev_addr_next = `DEV_DATA_IDX;
                if (phase_next == two_wire_seq_pkg::PH_ADDR) begin
                    dev_wdata_next = {target_reg, read_dir_reg};
                end else begin
                    dev_wdata_next = txdata_reg;
                end
            end
            two_wire_seq_pkg::S_KICK: begin
                // flag with enable resumes the bus
                dev_wdata_next = ctl_word(1'b0, 1'b0);
            end
            two_wire_seq_pkg::S_STOP: begin
                dev_wdata_next = ctl_word(1'b0, 1'b1);
            end
            default: ;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            DEV_ADDR <= `DEV_CONTROL_IDX;
            DEV_WDATA <= 8'h00;
        end else begin
            DEV_ADDR <= dev_addr_next;
            DEV_WDATA <= dev_wdata_next;
        end
    end

endmodule

// ===== verification/two_wire_seq_props.sv
`include "two_wire_seq_regs.svh"

module two_wire_seq_props (
    input wire logic CLK_SYS, // clock
    input wire logic NRST, // reset, active low
    input wire logic [4:0] AVS_ADDRESS, // address
    input wire logic AVS_READ, // read
    input wire logic AVS_WRITE, // write
    input wire logic [31:0] AVS_WRITEDATA, // write data
    input wire logic [31:0] AVS_READDATA, // read data
    input wire logic AVS_WAITREQUEST, // stall
    input wire logic [1:0] DEV_ADDR, // device index
    input wire logic DEV_WR, // device write
    input wire logic DEV_RD, // device read
    input wire logic [7:0] DEV_WDATA, // device write data
    input wire logic [7:0] DEV_RDATA // device read data
);
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    logic ctl_wr;
    assign ctl_wr = DEV_WR && DEV_ADDR == `DEV_CONTROL_IDX;
    ////////////////////////////////////////////////////////////////
    property p_one_wait; (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST; endproperty
    a_one_wait: assert property (p_one_wait) else $error("more than one wait state");
    property p_no_stall; !(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST; endproperty
    a_no_stall: assert property (p_no_stall) else $error("stall without request");
    property p_rd_gap; DEV_RD |=> !DEV_RD && !DEV_WR; endproperty
    a_rd_gap: assert property (p_rd_gap) else $error("no check cycle after read");
    property p_index_ok; DEV_RD || DEV_WR |-> DEV_ADDR != 2'h3 && !(DEV_RD && DEV_WR); endproperty
    a_index_ok: assert property (p_index_ok) else $error("bad device access");
    property p_start_cmd; ctl_wr && DEV_WDATA[`CTL_START_BIT] |-> DEV_WDATA == 8'hA4; endproperty
    a_start_cmd: assert property (p_start_cmd) else $error("bad start command");
    property p_stop_cmd; ctl_wr && DEV_WDATA[`CTL_STOP_BIT] |-> DEV_WDATA == 8'h94; endproperty
    a_stop_cmd: assert property (p_stop_cmd) else $error("bad stop command");
    property p_kick_cmd; ctl_wr && !DEV_WDATA[5] && !DEV_WDATA[4] |-> DEV_WDATA == 8'h84; endproperty
    a_kick_cmd: assert property (p_kick_cmd) else $error("bad continue command");
    property p_data_kick; DEV_WR && DEV_ADDR == `DEV_DATA_IDX |-> ##[1:4] ctl_wr && DEV_WDATA == 8'h84; endproperty
    a_data_kick: assert property (p_data_kick) else $error("byte loaded but not sent");
    property p_suspend; ctl_wr |=> (!DEV_WR) [*2]; endproperty
    a_suspend: assert property (p_suspend) else $error("write before flag polled");
    c_start: cover property (ctl_wr && DEV_WDATA == 8'hA4);
    c_stop: cover property (ctl_wr && DEV_WDATA == 8'h94);
    c_read: cover property (AVS_READ && !AVS_WAITREQUEST);
endmodule

bind two_wire_mode_sequencer two_wire_seq_props props_u (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .DEV_ADDR(DEV_ADDR), .DEV_WR(DEV_WR),
    .DEV_RD(DEV_RD), .DEV_WDATA(DEV_WDATA), .DEV_RDATA(DEV_RDATA));

// ===== verification/two_wire_dev_model.sv
`include "two_wire_seq_regs.svh"

module two_wire_dev_model (
    input wire logic clk, // system clock
    input wire logic nrst, // reset, active low
    input wire logic [1:0] dev_addr, // register index
    input wire logic dev_wr, // write strobe
    input wire logic dev_rd, // read strobe
    input wire logic [7:0] dev_wdata, // write data
    output logic [7:0] dev_rdata, // read data
    input wire logic [7:0] addr_resp, // code after address byte
    input wire logic [7:0] data_resp, // code after data byte
    input wire logic [3:0] delay, // bus time per event
    output logic [7:0] addr_byte, // last address byte on wire
    output logic [7:0] wire_byte, // last data byte on wire
    output int stop_count // stops generated
);
    logic [7:0] control_reg, status_reg, data_reg, rd_q;
    logic [1:0] presc, pend;
    logic [4:0] cnt;
    logic addr_phase, rd_valid;
    // released read port shows the inverse, never stale data
    assign dev_rdata = rd_valid ? rd_q : ~rd_q;
    ////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {control_reg, status_reg, data_reg, rd_q, presc, pend, cnt} <= '0;
            {addr_phase, rd_valid, addr_byte, wire_byte} <= '0;
            stop_count <= 0;
        end else begin
            rd_valid <= dev_rd;
            if (dev_rd) begin
                case (dev_addr)
                    `DEV_CONTROL_IDX: rd_q <= control_reg;
                    `DEV_STATUS_IDX: rd_q <= {status_reg[7:3], 1'b0, presc};
                    default: rd_q <= data_reg;
                endcase
            end
            if (dev_wr && dev_addr == `DEV_STATUS_IDX) presc <= dev_wdata[1:0];
            if (dev_wr && dev_addr == `DEV_DATA_IDX) begin
                if (control_reg[`CTL_FLAG_BIT]) data_reg <= dev_wdata;
                else control_reg[`CTL_WCOL_BIT] <= 1'b1;
            end
            if (dev_wr && dev_addr == `DEV_CONTROL_IDX && dev_wdata[7] && dev_wdata[2]) begin
                control_reg <= {1'b0, dev_wdata[6:4], control_reg[3], dev_wdata[2:0]};
                cnt <= {1'b0, delay} + 5'h01;
                pend <= dev_wdata[5] ? 2'h1 : (dev_wdata[4] ? 2'h3 : 2'h2);
            end else if (cnt > 5'h01) begin
                cnt <= cnt - 5'h01;
            end else if (cnt == 5'h01) begin
                cnt <= 5'h00;
                control_reg[`CTL_FLAG_BIT] <= pend != 2'h3;
                if (pend == 2'h1) begin
                    status_reg <= `CODE_START;
                    addr_phase <= 1'b1;
                end
                if (pend == 2'h2 && addr_phase) begin
                    addr_byte <= data_reg;
                    status_reg <= addr_resp;
                    addr_phase <= 1'b0;
                end
                if (pend == 2'h2 && !addr_phase) begin
                    wire_byte <= data_reg;
                    status_reg <= data_resp;
                end
                if (pend == 2'h3) begin
                    control_reg[`CTL_STOP_BIT] <= 1'b0;
                    stop_count <= stop_count + 1;
                end
            end
        end
    end
endmodule

// ===== verification/two_wire_mode_status_sequencer_tb.sv
`include "two_wire_seq_regs.svh"

module two_wire_mode_status_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic [31:0] exp; logic [31:0] mask;} note_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [4:0] av_addr = 5'h00;
    logic av_rd = 1'b0;
    logic av_wr = 1'b0;
    logic [31:0] av_wdata = 32'h0;
    logic [31:0] av_rdata, r;
    logic av_wait, dev_wr, dev_rd, rd, sp, err;
    logic [1:0] dev_addr;
    logic [7:0] dev_wdata, dev_rdata, addr_byte, wire_byte, a, code;
    logic [7:0] addr_resp = 8'h18;
    logic [7:0] data_resp = 8'h28;
    logic [3:0] delay = 4'h4;
    logic [6:0] tgt;
    logic [7:0] tx;
    int stop_count, base;
    int fail_count = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h9EA1663B;
    note_t notes[$];
    note_t cur;
    // rd, stop, address answer, data answer
    localparam logic [17:0] TBL [6] = '{{2'b01, 16'h1828}, {2'b01, 16'h2028}, {2'b01, 16'h3828},
        {2'b01, 16'h1820}, {2'b11, 16'h1828}, {2'b00, 16'h1828}};

    always #12.5 clk = ~clk;

    two_wire_mode_sequencer dut_u (.CLK_SYS(clk), .NRST(nrst), .AVS_ADDRESS(av_addr), .AVS_READ(av_rd),
        .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait),
        .DEV_ADDR(dev_addr), .DEV_WR(dev_wr), .DEV_RD(dev_rd), .DEV_WDATA(dev_wdata), .DEV_RDATA(dev_rdata));
    two_wire_dev_model dev_u (.clk(clk), .nrst(nrst), .dev_addr(dev_addr), .dev_wr(dev_wr), .dev_rd(dev_rd),
        .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .addr_resp(addr_resp), .data_resp(data_resp),
        .delay(delay), .addr_byte(addr_byte), .wire_byte(wire_byte), .stop_count(stop_count));
    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic av_write(input logic [4:0] ad, input logic [31:0] d);
        av_addr <= ad;
        av_wdata <= d;
        av_wr <= 1'b1;
        do @(posedge clk); while (av_wait !== 1'b0);
        av_wr <= 1'b0;
        @(posedge clk);
    endtask

    task automatic av_read(input logic [4:0] ad, input logic [31:0] e, input logic [31:0] m, output logic [31:0] d);
        notes.push_back('{e, m});
        av_addr <= ad;
        av_rd <= 1'b1;
        do @(posedge clk); while (av_wait !== 1'b0);
        d = av_rdata;
        av_rd <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h1;
        while (s[0] !== 1'b0) av_read(`HOST_STATUS_OFS, 32'h0, 32'h0, s);
    endtask
    ////////////////////////////////////////////////////////////////
    // compares each read whose note has a nonzero mask against the oldest note
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (av_rd && av_wait === 1'b0) begin
            cur = notes.pop_front();
            if (cur.mask != 32'h0) check(av_rdata & cur.mask, cur.exp & cur.mask);
        end
        if (cycles == 20000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        av_read(`HOST_STATUS_OFS, 32'h0, 32'hFF1F, r);
        av_read(5'h14, 32'h0, 32'hFFFFFFFF, r);
        for (int k = 0; k < 6; k++) begin
            rng = xs(rng);
            tgt = rng[6:0];
            tx = rng[15:8];
            {rd, sp, a} = TBL[k][17:8];
            addr_resp <= a;
            data_resp <= TBL[k][7:0];
            delay <= rng[19:16] | 4'h4;
            code = (a != `CODE_ADDR_ACK || rd) ? a : TBL[k][7:0];
            err = !rd && code != `CODE_DATA_ACK;
            base = stop_count;
            av_write(`HOST_PRESC_OFS, {30'h0, rng[21:20]});
            av_write(`HOST_TARGET_OFS, {25'h0, tgt});
            av_write(`HOST_TXDATA_OFS, {24'h0, tx});
            av_write(`HOST_CMD_OFS, {29'h0, sp, rd, 1'b1});
            // target change while busy must be ignored
            av_write(`HOST_TARGET_OFS, {25'h0, ~tgt});
            av_read(`HOST_STATUS_OFS, 32'h1, 32'h1, r);
            wait_idle();
            av_read(`HOST_STATUS_OFS, {16'h0, code, 4'h0, a == `CODE_ARB_LOST, err, 2'b10},
                32'hFF1F, r);
            check({24'h0, addr_byte}, {24'h0, tgt, rd});
            if (!rd && a == `CODE_ADDR_ACK) check({24'h0, wire_byte}, {24'h0, tx});
            check(32'(stop_count), 32'(base + int'(a != `CODE_ARB_LOST && (sp || err || rd))));
        end
        av_write(`HOST_STATUS_OFS, 32'h1E);
        av_read(`HOST_STATUS_OFS, 32'h0, 32'h1E, r);
        test_done();
    end
endmodule
